// ---- rtl/ebh_pkg.sv ----
// Shared constants and types of the bridge interrupt host controller
package ebh_pkg;

  // Device register offsets inside the control/status slave window
  localparam logic [31:0] DEV_IRQ_STATUS  = 32'h0000_0040;
  localparam logic [31:0] DEV_IRQ_ENABLE  = 32'h0000_0050;
  localparam logic [31:0] DEV_BUS_IRQ_EN  = 32'h0000_3070;
  localparam logic [31:0] DEV_L2B_STATUS  = 32'h0000_3060;

  // Configuration space offsets and control bits
  localparam logic [31:0] CFG_COMMAND     = 32'h0000_0004;
  localparam logic [31:0] CFG_MSG_CTRL    = 32'h0000_0050;
  localparam int          CMD_INTX_DIS    = 10;
  localparam int          MSG_EN_BIT      = 16;

  // Mailbox flag bits in the status word
  localparam logic [31:0] MBOX_MASK       = 32'h00ff_0000;

  // Own register offsets on the software port
  localparam logic [7:0]  SW_CTRL         = 8'h00;
  localparam logic [7:0]  SW_STAT         = 8'h04;
  localparam logic [7:0]  SW_LINK_EN      = 8'h08;
  localparam logic [7:0]  SW_BUS_EN       = 8'h0c;
  localparam logic [7:0]  SW_LAST_ST      = 8'h10;
  localparam logic [7:0]  SW_LAST_MB      = 8'h14;
  localparam logic [2:0]  SW_TBL_PAGE     = 3'h1;

  // Control word fields
  localparam int          CTRL_GO_MSI     = 0;
  localparam int          CTRL_GO_LEG     = 1;
  localparam int          CTRL_PROG_EN    = 2;
  localparam int          CTRL_SEND       = 3;
  localparam int          CTRL_IDX_LSB    = 4;
  localparam int          CTRL_AUTO       = 8;
  localparam int          CTRL_LEG_REQ    = 9;

  // Status word fields
  localparam int          STAT_BUSY       = 0;
  localparam int          STAT_MSI        = 1;
  localparam int          STAT_ERR        = 2;

  // Reset values
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;

  typedef enum logic [9:0] {
    S_IDLE    = 10'h001,
    S_EN_LINK = 10'h002,
    S_EN_BUS  = 10'h004,
    S_CFG_RD  = 10'h008,
    S_CFG_WR  = 10'h010,
    S_ST_RD   = 10'h020,
    S_ST_CLR  = 10'h040,
    S_MB_RD   = 10'h080,
    S_MB_CLR  = 10'h100,
    S_MSG_WR  = 10'h200
  } ebh_state_t;

  typedef enum logic [2:0] {
    M_IDLE  = 3'h1,
    M_SETUP = 3'h2,
    M_ACC   = 3'h4
  } ebh_mstate_t;

endpackage : ebh_pkg

// ---- rtl/ebh_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module ebh_sync
  import ebh_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } ebh_sync_t;

  ebh_sync_t r_q;
  ebh_sync_t r_d;

  always_comb begin
    r_d     = r_q;
    r_d.s1  = din;
    r_d.s2  = r_q.s1;
    r_d.s3  = r_q.s2;
    // Only stages two and three vote; stage one stays private
    for (int i = 0; i < W; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.out[i] = r_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign dout = r_q.out;

endmodule : ebh_sync

// ---- rtl/ebh_apb_master.sv ----
// APB master sequencer toward the bridge control/status and config windows
`timescale 1ns/10ps
module ebh_apb_master
  import ebh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             done,
  output logic             done_err,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);

  typedef struct packed {
    ebh_mstate_t st;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ebh_mst_t;

  ebh_mst_t r_q;
  ebh_mst_t r_d;

  always_comb begin
    r_d = r_q;
    unique case (r_q.st)
      M_IDLE: begin
        // Request is latched so the pins hold steady until completion
        if (req) begin
          r_d.st    = M_SETUP;
          r_d.write = req_write;
          r_d.addr  = req_addr;
          r_d.wdata = req_wdata;
        end
      end
      M_SETUP: r_d.st = M_ACC;
      M_ACC: begin
        if (pready) begin
          r_d.st = M_IDLE;
        end
      end
      default: r_d.st = M_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= '{st: M_IDLE, write: 1'b0, addr: '0, wdata: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign psel     = (r_q.st == M_SETUP) || (r_q.st == M_ACC);
  assign penable  = (r_q.st == M_ACC);
  assign pwrite   = r_q.write;
  assign paddr    = r_q.addr;
  assign pwdata   = r_q.wdata;
  assign done     = (r_q.st == M_ACC) && pready;
  assign done_err = (r_q.st == M_ACC) && pready && pslverr;

endmodule : ebh_apb_master

// ---- rtl/ebh_host.sv ----
// Host-side interrupt service controller for the bus bridge endpoint
`timescale 1ns/10ps
module ebh_host
  import ebh_pkg::*;
#(
  parameter int          NIRQ     = 16,
  parameter int          TBL_N    = 4,
  parameter logic [31:0] CRA_BASE = 32'h0000_0000,
  parameter logic [31:0] CFG_BASE = 32'h0001_0000
) (
  input  wire logic            clk,
  input  wire logic            rst,
  // Software port
  input  wire logic            s_psel,
  input  wire logic            s_penable,
  input  wire logic            s_pwrite,
  input  wire logic [7:0]      s_paddr,
  input  wire logic [31:0]     s_pwdata,
  output logic      [31:0]     s_prdata,
  output logic                 s_pready,
  output logic                 s_pslverr,
  // Master toward the bridge
  output logic                 m_psel,
  output logic                 m_penable,
  output logic                 m_pwrite,
  output logic      [31:0]     m_paddr,
  output logic      [31:0]     m_pwdata,
  input  wire logic [31:0]     m_prdata,
  input  wire logic            m_pready,
  input  wire logic            m_pslverr,
  // Interrupt pins
  input  wire logic            link_irq,
  input  wire logic            bus_irq,
  output logic      [NIRQ-1:0] bus_irq_clear,
  output logic                 legacy_irq_request,
  output logic                 busy
);

  // Refuse sizes the status word and table index cannot serve
  if (NIRQ < 1 || NIRQ > 16) begin : g_bad_nirq
    $error("NIRQ must be 1 to 16");
  end
  if (TBL_N < 1 || TBL_N > 4) begin : g_bad_tbl
    $error("TBL_N must be 1 to 4");
  end

  localparam logic [31:0] IN_MASK  = 32'((64'h1 << NIRQ) - 64'h1);
  localparam logic [31:0] ALL_MASK = IN_MASK | MBOX_MASK;

  typedef struct packed {
    ebh_state_t                  st;
    logic                        auto_svc;
    logic                        leg_req;
    logic [31:0]                 link_en;
    logic [31:0]                 bus_en;
    logic [31:0]                 last_st;
    logic [31:0]                 last_mb;
    logic [31:0]                 rdata;
    logic                        phase;
    logic                        to_msi;
    logic                        mode_msi;
    logic                        err;
    logic [1:0]                  idx;
    logic [NIRQ-1:0]             clr;
    logic [TBL_N-1:0][31:0]      tbl_addr;
    logic [TBL_N-1:0][31:0]      tbl_data;
  } ebh_host_t;

  ebh_host_t r_q;
  ebh_host_t r_d;

  logic [1:0]  irq_s;
  logic        m_req;
  logic        m_write;
  logic [31:0] m_addr;
  logic [31:0] m_wdata;
  logic        m_done;
  logic        m_err;
  logic        sw_wr;
  logic        sw_acc;
  logic        sw_hit;
  logic [31:0] sw_rd;
  logic [4:0]  pick;
  logic [31:0] cfg_off;
  logic [31:0] cfg_bit;
  logic [31:0] pend;

  // Lowest set bit; service order is the host's own choice
  function automatic logic [4:0] lowest_one(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) r = 5'(i);
    end
    return r;
  endfunction : lowest_one

  function automatic logic tbl_hit(input logic [7:0] a);
    return (a[7:5] == SW_TBL_PAGE) && (int'(a[4:3]) < TBL_N);
  endfunction : tbl_hit

  ebh_sync #(.W(2)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({bus_irq, link_irq}),
    .dout (irq_s)
  );

  ebh_apb_master u_mst (
    .clk       (clk),
    .rst       (rst),
    .req       (m_req),
    .req_write (m_write),
    .req_addr  (m_addr),
    .req_wdata (m_wdata),
    .done      (m_done),
    .done_err  (m_err),
    .psel      (m_psel),
    .penable   (m_penable),
    .pwrite    (m_pwrite),
    .paddr     (m_paddr),
    .pwdata    (m_pwdata),
    .pready    (m_pready),
    .pslverr   (m_pslverr)
  );

  // Software port: zero wait state, errors on unmapped words
  assign sw_acc = s_psel && s_penable;
  assign sw_wr  = sw_acc && s_pwrite;
  assign sw_hit = (s_paddr == SW_CTRL) || (s_paddr == SW_STAT) ||
                  (s_paddr == SW_LINK_EN) || (s_paddr == SW_BUS_EN) ||
                  (s_paddr == SW_LAST_ST) || (s_paddr == SW_LAST_MB) ||
                  tbl_hit(s_paddr);
  assign s_pready  = 1'b1;
  assign s_pslverr = sw_acc && !sw_hit;

  always_comb begin
    sw_rd = '0;
    if (tbl_hit(s_paddr)) begin
      sw_rd = s_paddr[2] ? r_q.tbl_data[s_paddr[4:3]] : r_q.tbl_addr[s_paddr[4:3]];
    end else begin
      unique case (s_paddr)
        SW_CTRL: begin
          sw_rd[CTRL_AUTO]    = r_q.auto_svc;
          sw_rd[CTRL_LEG_REQ] = r_q.leg_req;
        end
        SW_STAT: begin
          sw_rd[STAT_BUSY] = (r_q.st != S_IDLE);
          sw_rd[STAT_MSI]  = r_q.mode_msi;
          sw_rd[STAT_ERR]  = r_q.err;
        end
        SW_LINK_EN: sw_rd = r_q.link_en;
        SW_BUS_EN:  sw_rd = r_q.bus_en;
        SW_LAST_ST: sw_rd = r_q.last_st;
        SW_LAST_MB: sw_rd = r_q.last_mb;
        default:    sw_rd = '0;
      endcase
    end
  end
  assign s_prdata = sw_rd;

  // Config step order: new type enabled first, old one disabled second
  assign cfg_off = (r_q.phase == r_q.to_msi) ? CFG_COMMAND : CFG_MSG_CTRL;
  assign cfg_bit = (cfg_off == CFG_MSG_CTRL) ? (32'h1 << MSG_EN_BIT)
                                             : (32'h1 << CMD_INTX_DIS);
  assign pend    = m_prdata & ALL_MASK;
  assign pick    = lowest_one(pend);

  // Request toward the bridge is decoded from registered fields alone, not the state only
  always_comb begin
    m_req   = 1'b1;
    m_write = 1'b1;
    m_addr  = '0;
    m_wdata = '0;
    unique case (r_q.st)
      S_IDLE: m_req = 1'b0;
      S_EN_LINK: begin
        m_addr  = CRA_BASE + DEV_IRQ_ENABLE;
        m_wdata = r_q.link_en;
      end
      S_EN_BUS: begin
        m_addr  = CRA_BASE + DEV_BUS_IRQ_EN;
        m_wdata = r_q.bus_en;
      end
      S_CFG_RD: begin
        m_write = 1'b0;
        m_addr  = CFG_BASE + cfg_off;
      end
      S_CFG_WR: begin
        m_addr  = CFG_BASE + cfg_off;
        m_wdata = r_q.to_msi ? (r_q.rdata | cfg_bit) : (r_q.rdata & ~cfg_bit);
      end
      S_ST_RD: begin
        m_write = 1'b0;
        m_addr  = CRA_BASE + DEV_IRQ_STATUS;
      end
      S_ST_CLR: begin
        m_addr  = CRA_BASE + DEV_IRQ_STATUS;
        m_wdata = 32'h1 << lowest_one(r_q.last_st & MBOX_MASK);
      end
      S_MB_RD: begin
        m_write = 1'b0;
        m_addr  = CRA_BASE + DEV_L2B_STATUS;
      end
      S_MB_CLR: begin
        m_addr  = CRA_BASE + DEV_L2B_STATUS;
        m_wdata = 32'h1 << lowest_one(r_q.last_mb);
      end
      S_MSG_WR: begin
        m_addr  = r_q.tbl_addr[r_q.idx];
        m_wdata = r_q.tbl_data[r_q.idx];
      end
    endcase
  end

  always_comb begin
    r_d     = r_q;
    r_d.clr = '0;

    if (sw_wr) begin
      if (s_paddr == SW_CTRL) begin
        r_d.auto_svc = s_pwdata[CTRL_AUTO];
        r_d.leg_req  = s_pwdata[CTRL_LEG_REQ];
      end
      if (s_paddr == SW_LINK_EN) r_d.link_en = s_pwdata;
      if (s_paddr == SW_BUS_EN) r_d.bus_en = s_pwdata;
      if (s_paddr == SW_STAT && s_pwdata[STAT_ERR]) r_d.err = 1'b0;
      // Root port programs the message table through this port
      if (tbl_hit(s_paddr)) begin
        if (s_paddr[2]) r_d.tbl_data[s_paddr[4:3]] = s_pwdata;
        else r_d.tbl_addr[s_paddr[4:3]] = s_pwdata;
      end
    end

    // Set wins over the software clear in the same cycle
    if (m_err) r_d.err = 1'b1;

    unique case (r_q.st)
      S_IDLE: begin
        // Commands landing while busy are dropped, not queued
        if (sw_wr && s_paddr == SW_CTRL &&
            (s_pwdata[CTRL_GO_MSI] || s_pwdata[CTRL_GO_LEG])) begin
          r_d.to_msi = s_pwdata[CTRL_GO_MSI];
          r_d.phase  = 1'b0;
          r_d.st     = S_CFG_RD;
        end else if (sw_wr && s_paddr == SW_CTRL && s_pwdata[CTRL_PROG_EN]) begin
          r_d.st = S_EN_LINK;
        end else if (sw_wr && s_paddr == SW_CTRL && s_pwdata[CTRL_SEND]) begin
          r_d.idx = s_pwdata[CTRL_IDX_LSB +: 2] & 2'(TBL_N - 1);
          r_d.st  = S_MSG_WR;
        end else if (r_q.auto_svc && irq_s[0]) begin
          r_d.st = S_ST_RD;
        end else if (r_q.auto_svc && irq_s[1]) begin
          r_d.st = S_MB_RD;
        end
      end
      S_EN_LINK: if (m_done) r_d.st = S_EN_BUS;
      S_EN_BUS:  if (m_done) r_d.st = S_IDLE;
      S_CFG_RD: begin
        if (m_done) begin
          r_d.rdata = m_prdata;
          r_d.st    = S_CFG_WR;
        end
      end
      S_CFG_WR: begin
        if (m_done) begin
          if (!r_q.phase) begin
            r_d.phase = 1'b1;
            r_d.st    = S_CFG_RD;
          end else begin
            r_d.mode_msi = r_q.to_msi;
            r_d.st       = S_IDLE;
          end
        end
      end
      S_ST_RD: begin
        if (m_done) begin
          r_d.last_st = m_prdata;
          if (pend == '0) begin
            r_d.st = S_IDLE;
          end else if (MBOX_MASK[pick]) begin
            r_d.st = S_ST_CLR;
          end else begin
            // One bit per pass; the re-read picks up the rest
            for (int i = 0; i < NIRQ; i++) begin
              if (5'(i) == pick) r_d.clr[i] = 1'b1;
            end
          end
        end
      end
      S_ST_CLR: if (m_done) r_d.st = S_ST_RD;
      S_MB_RD: begin
        if (m_done) begin
          r_d.last_mb = m_prdata;
          r_d.st      = (m_prdata == '0) ? S_IDLE : S_MB_CLR;
        end
      end
      S_MB_CLR:  if (m_done) r_d.st = S_MB_RD;
      S_MSG_WR:  if (m_done) r_d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q          <= '0;
      r_q.st       <= S_IDLE;
      r_q.link_en  <= RST_WORD;
      r_q.bus_en   <= RST_WORD;
    end else begin
      r_q <= r_d;
    end
  end

  assign bus_irq_clear      = r_q.clr;
  assign legacy_irq_request = r_q.leg_req;
  assign busy               = (r_q.st != S_IDLE);

endmodule : ebh_host

// ---- tb/ebh_host_assertions.sv ----
// Port checks on the host controller: bus handshake and service order
`timescale 1ns/10ps
module ebh_host_assertions
  import ebh_pkg::*;
#(
  parameter int          NIRQ     = 16,
  parameter logic [31:0] CRA_BASE = 32'h0000_0000,
  parameter logic [31:0] CFG_BASE = 32'h0001_0000
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            s_psel,
  input wire logic            s_penable,
  input wire logic            s_pwrite,
  input wire logic [7:0]      s_paddr,
  input wire logic [31:0]     s_pwdata,
  input wire logic            s_pslverr,
  input wire logic            m_psel,
  input wire logic            m_penable,
  input wire logic            m_pwrite,
  input wire logic [31:0]     m_paddr,
  input wire logic [31:0]     m_pwdata,
  input wire logic            m_pready,
  input wire logic [NIRQ-1:0] bus_irq_clear,
  input wire logic            legacy_irq_request,
  input wire logic            busy
);
  logic done, wr, rd40, msg_on_q, dis_q;
  assign done = m_psel && m_penable && m_pready;
  assign wr   = done && m_pwrite;
  assign rd40 = done && !m_pwrite && m_paddr == CRA_BASE + DEV_IRQ_STATUS;
  // Mode bits as last written by the host
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_on_q <= 1'b0;
      dis_q    <= 1'b0;
    end else if (wr && m_paddr == CFG_BASE + CFG_MSG_CTRL) begin
      msg_on_q <= m_pwdata[MSG_EN_BIT];
    end else if (wr && m_paddr == CFG_BASE + CFG_COMMAND) begin
      dis_q <= m_pwdata[CMD_INTX_DIS];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_setup;
    $rose(m_psel) |-> !m_penable ##1 (m_psel && m_penable);
  endproperty
  a_setup: assert property (p_setup) else $error("master access phase missing");
  property p_hold;
    m_psel && m_penable && !m_pready |=> m_psel && m_penable && $stable(m_paddr)
      && $stable(m_pwrite) && $stable(m_pwdata);
  endproperty
  a_hold: assert property (p_hold) else $error("master request changed in wait");
  property p_gap;
    done |=> !m_psel;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle after transfer");
  property p_to_msg;
    wr && m_paddr == CFG_BASE + CFG_COMMAND && m_pwdata[CMD_INTX_DIS] |-> msg_on_q;
  endproperty
  a_to_msg: assert property (p_to_msg) else $error("wire disabled first");
  property p_to_leg;
    wr && m_paddr == CFG_BASE + CFG_MSG_CTRL && !m_pwdata[MSG_EN_BIT] |-> !dis_q;
  endproperty
  a_to_leg: assert property (p_to_leg) else $error("message disabled first");
  property p_mb_clr;
    wr && m_paddr == CRA_BASE + DEV_IRQ_STATUS |-> $onehot(m_pwdata)
      && (m_pwdata & ~MBOX_MASK) == 32'h0 ##[1:4] (m_psel && !m_pwrite && m_paddr == 
      CRA_BASE + DEV_IRQ_STATUS);
  endproperty
  a_mb_clr: assert property (p_mb_clr) else $error("bad mailbox clear");
  property p_l2b;
    wr && m_paddr == CRA_BASE + DEV_L2B_STATUS |-> $onehot(m_pwdata) ##[1:4]
      (m_psel && !m_pwrite && m_paddr == CRA_BASE + DEV_L2B_STATUS);
  endproperty
  a_l2b: assert property (p_l2b) else $error("bad bus-side status clear");
  property p_clr;
    |bus_irq_clear |-> $onehot(bus_irq_clear) && $past(rd40) ##1 bus_irq_clear == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("bad source clear pulse");
  property p_leg;
    s_psel && s_penable && s_pwrite && s_paddr == SW_CTRL |=>
      legacy_irq_request == $past(s_pwdata[CTRL_LEG_REQ]);
  endproperty
  a_leg: assert property (p_leg) else $error("wire request level wrong");
  property p_hole;
    s_psel && s_penable && s_paddr == 8'h18 |-> s_pslverr;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped access accepted");
  property p_done;
    $rose(busy) |-> ##[1:250] !busy;
  endproperty
  a_done: assert property (p_done) else $error("service sequence never ended");
endmodule : ebh_host_assertions

bind ebh_host ebh_host_assertions #(.NIRQ(NIRQ), .CRA_BASE(CRA_BASE), .CFG_BASE(CFG_BASE))
  u_chk (.clk(clk), .rst(rst), .s_psel(s_psel), .s_penable(s_penable), .s_pwrite(s_pwrite),
  .s_paddr(s_paddr), .s_pwdata(s_pwdata), .s_pslverr(s_pslverr), .m_psel(m_psel),
  .m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr), .m_pwdata(m_pwdata),
  .m_pready(m_pready), .bus_irq_clear(bus_irq_clear),
  .legacy_irq_request(legacy_irq_request), .busy(busy));

// ---- tb/ebh_dev_model.sv ----
// Behavioural bridge: device registers, interrupt sources, optional slow answers
`timescale 1ns/10ps
module ebh_dev_model
  import ebh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow,
  input  wire logic [15:0] src_set,
  input  wire logic [15:0] src_clr,
  input  wire logic [7:0]  mb_set,
  input  wire logic [7:0]  l2b_set,
  output logic             link_irq,
  output logic             bus_irq
);
  logic [15:0] src_q;
  logic [7:0]  mb_q, l2b_q;
  logic [31:0] en_q, busen_q, cmd_q, msg_q, lw_a, lw_d, rdv, st;
  logic [1:0]  cnt_q;
  logic        wr, hit;
  assign st      = {8'h00, mb_q, src_q};
  assign pready  = psel && penable && (!slow || cnt_q == 2'd2);
  assign wr      = pready && pwrite;
  assign pslverr = pready && !hit;
  // Bus shows junk outside the access so stale data cannot pass
  assign prdata  = pready ? rdv : ~rdv;
  assign link_irq = |(st & en_q) && (msg_q[16] || !cmd_q[10]);
  assign bus_irq = |l2b_q && busen_q[0];
  always_comb begin
    hit = 1'b1;
    case (paddr)
      DEV_IRQ_STATUS: rdv = st;
      DEV_IRQ_ENABLE: rdv = en_q;
      DEV_BUS_IRQ_EN: rdv = busen_q;
      DEV_L2B_STATUS: rdv = {24'h0, l2b_q};
      32'h0001_0004:  rdv = cmd_q;
      32'h0001_0050:  rdv = msg_q;
      default: begin
        rdv = 32'h0;
        hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {src_q, mb_q, l2b_q, cnt_q} <= '0;
      {en_q, busen_q, cmd_q, msg_q, lw_a, lw_d} <= '0;
    end else begin
      cnt_q <= (psel && penable && !pready) ? cnt_q + 2'd1 : 2'd0;
      src_q <= (src_q | src_set) & ~src_clr;
      mb_q  <= (mb_q | mb_set) & ~((wr && paddr == DEV_IRQ_STATUS) ? pwdata[23:16] : 8'h0);
      l2b_q <= (l2b_q | l2b_set) & ~((wr && paddr == DEV_L2B_STATUS) ? pwdata[7:0] : 8'h0);
      if (wr) begin
        lw_a <= paddr;
        lw_d <= pwdata;
        if (paddr == DEV_IRQ_ENABLE) en_q <= pwdata;
        if (paddr == DEV_BUS_IRQ_EN) busen_q <= pwdata;
        if (paddr == 32'h0001_0004) cmd_q <= pwdata;
        if (paddr == 32'h0001_0050) msg_q <= pwdata;
      end
    end
  end
endmodule : ebh_dev_model

// ---- tb/ebh_host_bench.sv ----
// Self-checking bench for the host controller against the bridge model
`timescale 1ns/10ps
module ebh_host_bench;
  import ebh_pkg::*;
  logic        clk, rst, s_psel, s_penable, s_pwrite, slow, er_q;
  logic [7:0]  s_paddr, mb_set, l2b_set;
  logic [31:0] s_pwdata, rd_q;
  logic [15:0] src_set;
  wire  [31:0] s_prdata, m_paddr, m_pwdata, m_prdata;
  wire  [15:0] bus_irq_clear;
  wire         s_pready, s_pslverr, m_psel, m_penable, m_pwrite, m_pready, m_pslverr;
  wire         link_irq, bus_irq, legacy_irq_request, busy;
  int          n_errors = 0, n_checks = 0;

  ebh_host uut (.clk(clk), .rst(rst), .s_psel(s_psel), .s_penable(s_penable),
    .s_pwrite(s_pwrite), .s_paddr(s_paddr), .s_pwdata(s_pwdata), .s_prdata(s_prdata),
    .s_pready(s_pready), .s_pslverr(s_pslverr), .m_psel(m_psel), .m_penable(m_penable),
    .m_pwrite(m_pwrite), .m_paddr(m_paddr), .m_pwdata(m_pwdata), .m_prdata(m_prdata),
    .m_pready(m_pready), .m_pslverr(m_pslverr), .link_irq(link_irq), .bus_irq(bus_irq),
    .bus_irq_clear(bus_irq_clear), .legacy_irq_request(legacy_irq_request), .busy(busy));
  ebh_dev_model dev (.clk(clk), .rst(rst), .psel(m_psel), .penable(m_penable),
    .pwrite(m_pwrite), .paddr(m_paddr), .pwdata(m_pwdata), .prdata(m_prdata),
    .pready(m_pready), .pslverr(m_pslverr), .slow(slow), .src_set(src_set),
    .src_clr(bus_irq_clear), .mb_set(mb_set), .l2b_set(l2b_set), .link_irq(link_irq),
    .bus_irq(bus_irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic sw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_psel   <= 1'b1;
    s_pwrite <= w;
    s_paddr  <= a;
    s_pwdata <= d;
    @(posedge clk);
    s_penable <= 1'b1;
    @(posedge clk);
    while (s_pready !== 1'b1) @(posedge clk);
    rd_q = s_prdata;
    er_q = s_pslverr;
    s_psel    <= 1'b0;
    s_penable <= 1'b0;
  endtask : sw

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    sw(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask : rdc

  // Two passes: the synchronised request lags the device by a few cycles
  task automatic idle();
    for (int p = 0; p < 2; p++) begin
      repeat (6) @(negedge clk);
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk);
      chk(32'(busy), 32'h0);
    end
  endtask : idle

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    {rst, s_psel, s_penable, s_pwrite, slow} = 5'b10000;
    {s_paddr, s_pwdata, src_set, mb_set, l2b_set} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(32'(busy), 32'h0);
    chk(32'(legacy_irq_request), 32'h0);
    rdc(SW_LINK_EN, 32'h0);
    sw(1'b1, SW_LINK_EN, 32'h00ff_ffff);
    rdc(SW_LINK_EN, 32'h00ff_ffff);
    sw(1'b1, SW_BUS_EN, 32'h1);
    sw(1'b1, 8'h18, 32'h5);
    chk(32'(er_q), 32'h1);
    sw(1'b1, SW_CTRL, 32'h200);
    @(negedge clk);
    chk(32'(legacy_irq_request), 32'h1);
    rdc(SW_CTRL, 32'h200);
    $display("registers test done");
    sw(1'b1, SW_CTRL, 32'h4);
    idle();
    chk(dev.en_q, 32'h00ff_ffff);
    chk(dev.busen_q, 32'h1);
    $display("enable program test done");
    sw(1'b1, SW_CTRL, 32'h1);
    idle();
    chk({dev.msg_q[16], dev.cmd_q[10]}, 32'h3);
    rdc(SW_STAT, 32'h2);
    sw(1'b1, SW_CTRL, 32'h2);
    idle();
    chk({dev.msg_q[16], dev.cmd_q[10]}, 32'h0);
    rdc(SW_STAT, 32'h0);
    $display("mode switch test done");
    slow <= 1'b1;
    sw(1'b1, SW_CTRL, 32'h100);
    src_set <= 16'h8028;
    mb_set  <= 8'h82;
    @(posedge clk);
    src_set <= 16'h0;
    mb_set  <= 8'h0;
    idle();
    chk(32'(dev.src_q), 32'h0);
    chk(32'(dev.mb_q), 32'h0);
    rdc(SW_LAST_ST, 32'h0);
    l2b_set <= 8'h81;
    @(posedge clk);
    l2b_set <= 8'h0;
    idle();
    chk(32'(dev.l2b_q), 32'h0);
    rdc(SW_LAST_MB, 32'h0);
    $display("service test done");
    slow <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      sw(1'b1, 8'h20 + 8'(8 * i), 32'h0000_0900 + i);
      sw(1'b1, 8'h24 + 8'(8 * i), 32'hab00_0000 + i);
      sw(1'b1, SW_CTRL, 32'h8 + 32'(i << 4));
      idle();
      chk(dev.lw_a, 32'h0000_0900 + i);
      chk(dev.lw_d, 32'hab00_0000 + i);
    end
    rdc(SW_STAT, 32'h4);
    sw(1'b1, SW_STAT, 32'h4);
    rdc(SW_STAT, 32'h0);
    $display("send test done");
    end_sim();
  end
endmodule : ebh_host_bench
